// >>> rtl/adf_filter_ctrl.sv
// decimation filter control for two sigma-delta modulators, with the
// result fifo that feeds software
// assumes modulator bits asynchronous to clk_sys, a one-cycle register
// port and a result consumer with valid/ready
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "adf_defines.svh"

module adf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];   // storage words
    logic [AW-1:0]    wr_ptr_r;        // next slot to fill
    logic [AW-1:0]    rd_ptr_r;        // oldest word
    logic [AW:0]      level_r;         // words held
    wire              push_w = in_valid && in_ready;
    wire              pop_w  = out_valid && out_ready;

    // full and empty straight from the level count
    assign in_ready  = (level_r != (AW+1)'(DEPTH));
    assign out_valid = (level_r != '0);
    assign out_data  = mem_r[rd_ptr_r];

    // storage write, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (push_w) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            level_r <= level_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
        end
    end
endmodule : adf_fifo

module adf_filter_ctrl #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    input  wire logic [`ADF_ADDR_W-1:0]  reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [15:0]                  reg_rdata,
    input  wire logic [1:0]              mod_bit,
    output logic                         mod_chop,
    output logic                         conv_reset,
    output logic                         res_valid,
    input  wire logic                    res_ready,
    output adf_pkg::adf_res_t            res_data
);
    // registers
    adf_pkg::adf_cfg_t   cfg_r;         // filter_rate_register
    adf_pkg::adf_state_t state_r;       // sequencer state
    adf_pkg::adf_state_t state_nxt;
    logic [15:0]  reg_rdata_r;          // read data, one cycle late
    logic         overrun_r;            // result lost, fifo full
    logic         conv_reset_r;         // restart pulse to analog side
    logic         mod_chop_r;           // input swap phase
    logic [24:0]  phase_r;              // fractional modulator tick
    logic         tick_r;               // one modulator bit period
    logic [15:0]  win_cnt_r;            // modulator bits in window
    logic [11:0]  boot_cnt_r;           // first-result delay
    logic [2:0]   settle_cnt_r;         // windows done since restart
    logic         res_valid_r;          // output stage
    adf_pkg::adf_res_t res_data_r;
    logic [15:0]  res_ch [2];           // per-channel filtered value

    // register port decode
    wire ctrl_hit_w = (reg_addr == `ADF_CTRL_ADDR);
    wire stat_hit_w = (reg_addr == `ADF_STAT_ADDR);
    wire ctrl_wr_w  = reg_wr && ctrl_hit_w;
    wire ovr_clr_w  = reg_wr && stat_hit_w && reg_wdata[`ADF_ST_OVERRUN];
    wire [15:0] stat_w = {12'h000, state_r, overrun_r,
                          (state_r == adf_pkg::ADF_ST_RUN)};
    wire [15:0] rd_mux_w = ctrl_hit_w ? cfg_r :
                           stat_hit_w ? stat_w : 16'h0000;

    // effective modes
    wire ravg_eff_w = cfg_r.chop || cfg_r.ravg;
    wire af_on_w    = (cfg_r.af != 6'h00);

    // window length in modulator bits
    wire [31:0] base_w = ({25'h0, cfg_r.sf} + 32'h1) * `ADF_OSR_UNIT;
    wire [31:0] avg_w  = base_w * ({26'h0, cfg_r.af} + `ADF_AVG_BASE);
    wire [31:0] calc_w = cfg_r.chop ? avg_w + `ADF_CHOP_EXTRA :
                         af_on_w    ? avg_w : base_w;
    // the extra three bits under chop are the only rate gap with af>0
    wire [31:0] forced_w = (cfg_r.sf == `ADF_SF_FORCE60) ? `ADF_WIN_60 :
                           (cfg_r.sf == `ADF_SF_FORCE50) ? `ADF_WIN_50 :
                           calc_w;
    // illegal factor pairs would overflow the data path, so clamp
    wire [31:0] clamp_w = (forced_w > `ADF_WIN_MAX) ? `ADF_WIN_MAX
                                                    : forced_w;
    wire [15:0] n_win_w = clamp_w[15:0];

    // settling periods for the current mode
    wire [2:0] settle_need_w =
        cfg_r.chop ? `ADF_SETTLE_CHOP :
        af_on_w    ? (cfg_r.ravg ? `ADF_SETTLE_AF_RA : `ADF_SETTLE_AF) :
                     (cfg_r.ravg ? `ADF_SETTLE_PLAIN_RA
                                 : `ADF_SETTLE_PLAIN);

    wire conv_on_w = (state_r != adf_pkg::ADF_ST_BOOT);
    wire win_end_w = conv_on_w && tick_r && (win_cnt_r == n_win_w - 16'h1);
    wire [2:0] settle_inc_w = settle_cnt_r + 3'h1;
    wire settled_w = (settle_inc_w >= settle_need_w);
    wire boot_done_w = (boot_cnt_r == 12'(`ADF_FIRST_DLY_CYC - 32'h1));

    // result fifo
    logic fifo_in_ready;
    logic fifo_out_valid;
    adf_pkg::adf_res_t fifo_out_data;
    wire push_w = win_end_w && settled_w && !ctrl_wr_w;
    wire load_w = !res_valid_r || res_ready;

    adf_fifo #(
        .WIDTH ($bits(adf_pkg::adf_res_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (push_w),
        .in_ready  (fifo_in_ready),
        .in_data   ({res_ch[1], res_ch[0]}),
        .out_valid (fifo_out_valid),
        .out_ready (load_w),
        .out_data  (fifo_out_data)
    );

    // register port: control write restarts converters
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_r        <= `ADF_CTRL_RESET;
            reg_rdata_r  <= 16'h0000;
            conv_reset_r <= 1'b0;
        end else begin
            if (ctrl_wr_w) begin
                cfg_r <= reg_wdata;
            end
            reg_rdata_r  <= reg_rd ? rd_mux_w : 16'h0000;
            conv_reset_r <= ctrl_wr_w;
        end
    end

    // overrun flag: a loss in the clearing cycle still sets it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overrun_r <= 1'b0;
        end else begin
            overrun_r <= (win_end_w && settled_w && !fifo_in_ready) ||
                         (overrun_r && !ovr_clr_w);
        end
    end

    // 512 kHz bit tick from 25 MHz by a fractional accumulator
    wire [24:0] phase_add_w = phase_r + 25'(`ADF_MOD_HZ);
    wire        phase_wrap_w = (phase_add_w >= 25'(`ADF_CLK_HZ));
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= 25'h0;
            tick_r  <= 1'b0;
        end else begin
            phase_r <= phase_wrap_w ? phase_add_w - 25'(`ADF_CLK_HZ)
                                    : phase_add_w;
            tick_r  <= phase_wrap_w;
        end
    end

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adf_pkg::ADF_ST_BOOT: begin
                if (boot_done_w) begin
                    state_nxt = adf_pkg::ADF_ST_SETTLE;
                end
            end
            adf_pkg::ADF_ST_SETTLE: begin
                if (win_end_w && settled_w) begin
                    state_nxt = adf_pkg::ADF_ST_RUN;
                end
            end
            adf_pkg::ADF_ST_RUN: begin
                state_nxt = adf_pkg::ADF_ST_RUN;
            end
        endcase
        if (ctrl_wr_w) begin
            state_nxt = adf_pkg::ADF_ST_BOOT;
        end
    end

    // sequencer and window counters
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r      <= adf_pkg::ADF_ST_BOOT;
            boot_cnt_r   <= 12'h000;
            win_cnt_r    <= 16'h0000;
            settle_cnt_r <= 3'h0;
            mod_chop_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (ctrl_wr_w || conv_on_w) begin
                boot_cnt_r <= 12'h000;
            end else begin
                boot_cnt_r <= boot_cnt_r + 12'h001;
            end
            if (ctrl_wr_w || win_end_w) begin
                win_cnt_r <= 16'h0000;
            end else if (conv_on_w && tick_r) begin
                win_cnt_r <= win_cnt_r + 16'h0001;
            end
            if (ctrl_wr_w) begin
                settle_cnt_r <= 3'h0;
            end else if (win_end_w && !settled_w) begin
                settle_cnt_r <= settle_inc_w;
            end
            // swap the modulator inputs each window
            if (ctrl_wr_w || !cfg_r.chop) begin
                mod_chop_r <= 1'b0;
            end else if (win_end_w) begin
                mod_chop_r <= !mod_chop_r;
            end
        end
    end

    // per-converter bit synchroniser and filter
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [2:0]  sync_r;    // three-stage capture
        logic        bit_r;     // accepted bit
        logic [15:0] acc_r;     // ones in window
        logic [15:0] prev_r;    // last raw window value
        logic [15:0] last_r;    // last averaged value, before the notch
        wire  [15:0] acc_fin_w = acc_r + 16'(bit_r);
        // chop: a swapped window counts the complementary bits
        wire  [15:0] raw_w = mod_chop_r ? n_win_w - acc_fin_w : acc_fin_w;
        wire  [16:0] pair_w = {1'b0, raw_w} + {1'b0, prev_r};
        wire  [15:0] avg2_w = ravg_eff_w ? pair_w[16:1] : raw_w;
        wire  [17:0] notch_w = {2'b00, avg2_w} + {1'b0, avg2_w, 1'b0} +
                               {2'b00, last_r};
        assign res_ch[c] = cfg_r.second_notch ? notch_w[17:2] : avg2_w;

        // a change counts once stages two and three agree
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                sync_r <= 3'b000;
                bit_r  <= 1'b0;
            end else begin
                sync_r <= {sync_r[1:0], mod_bit[c]};
                if (sync_r[1] == sync_r[2]) begin
                    bit_r <= sync_r[2];
                end
            end
        end

        // window accumulation, cleared by a restart
        always_ff @(posedge clk_sys) begin
            if (!rst_n || ctrl_wr_w) begin
                acc_r  <= 16'h0000;
                prev_r <= 16'h0000;
                last_r <= 16'h0000;
            end else if (win_end_w) begin
                acc_r  <= 16'h0000;
                prev_r <= raw_w;
                last_r <= avg2_w;
            end else if (conv_on_w && tick_r) begin
                acc_r  <= acc_fin_w;
            end
        end
    end

    // output stage fed from the fifo
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            res_valid_r <= 1'b0;
            res_data_r  <= '0;
        end else if (load_w) begin
            res_valid_r <= fifo_out_valid;
            res_data_r  <= fifo_out_data;
        end
    end

    assign reg_rdata  = reg_rdata_r;
    assign mod_chop   = mod_chop_r;
    assign conv_reset = conv_reset_r;
    assign res_valid  = res_valid_r;
    assign res_data   = res_data_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    wr_restart_a: assert property (ctrl_wr_w |=> conv_reset_r &&
        state_r == adf_pkg::ADF_ST_BOOT && win_cnt_r == 16'h0000)
        else $error("control write did not restart converters");
    boot_len_a: assert property (
        (state_r == adf_pkg::ADF_ST_BOOT && boot_done_w && !ctrl_wr_w)
        |=> state_r == adf_pkg::ADF_ST_SETTLE &&
            $past(boot_cnt_r) == 12'(`ADF_FIRST_DLY_CYC - 32'h1))
        else $error("first result delay wrong");
    chop_flip_a: assert property ((win_end_w && cfg_r.chop &&
        !ctrl_wr_w) |=> mod_chop_r != $past(mod_chop_r))
        else $error("chop phase did not toggle");
    chop_rate_a: assert property ((cfg_r.chop && !af_on_w &&
        cfg_r.sf <= `ADF_SF_LAST_CALC) |-> n_win_w ==
        16'(({25'h0, cfg_r.sf} + 32'h1) * 32'hc0 + 32'h3))
        else $error("chopped window not three times");
    base_rate_a: assert property ((!cfg_r.chop && !af_on_w &&
        cfg_r.sf <= `ADF_SF_LAST_CALC) |->
        n_win_w == 16'(({25'h0, cfg_r.sf} + 32'h1) * 32'h40))
        else $error("plain window length wrong");
    forced_rate_a: assert property (
        (cfg_r.sf == `ADF_SF_FORCE60) |-> n_win_w == 16'h2155)
        else $error("60 Hz window wrong");
    forced50_rate_a: assert property (
        (cfg_r.sf == `ADF_SF_FORCE50) |-> n_win_w == 16'h2800)
        else $error("50 Hz window wrong");
    min_rate_a: assert property (n_win_w <= 16'hc800)
        else $error("window beyond 10 Hz");
    chop_settle_a: assert property (cfg_r.chop |->
        settle_need_w == 3'h2 && ravg_eff_w)
        else $error("chop settling or average wrong");
    ravg_settle_a: assert property ((!cfg_r.chop &&
        cfg_r.ravg && !af_on_w) |-> settle_need_w == 3'h4)
        else $error("running average settling wrong");
    run_entry_a: assert property ($rose(state_r == adf_pkg::ADF_ST_RUN)
        |-> $past(push_w))
        else $error("run entered without a result");

    run_reach_c: cover property (state_r == adf_pkg::ADF_ST_RUN);
    overrun_c: cover property (overrun_r && ovr_clr_w);
    handshake_c: cover property (res_valid_r && res_ready);
    chop_run_c: cover property (cfg_r.chop && push_w);
endmodule : adf_filter_ctrl

// >>> rtl/adf_defines.svh
// constants of the decimation filter control block: offsets, fields,
// reset values and timing figures
// assumes a 25 MHz system clock and a 512 kHz modulator bit rate
`ifndef ADF_DEFINES_SVH
`define ADF_DEFINES_SVH

// register map (12-bit byte address on the plain register port)
`define ADF_ADDR_W        12
`define ADF_CTRL_ADDR     12'h518
`define ADF_STAT_ADDR     12'h5f0
`define ADF_CTRL_RESET    16'h0007

// control field positions
`define ADF_CHOP_BIT      15
`define ADF_RAVG_BIT      14
`define ADF_AF_MSB        13
`define ADF_AF_LSB        8
`define ADF_SECOND_NOTCH_BIT    7
`define ADF_SF_MSB        6
`define ADF_SF_LSB        0

// status field positions
`define ADF_ST_SETTLED    0
`define ADF_ST_OVERRUN    1

// decimation factor codes: last calculated one, then the two with fixed rates
`define ADF_SF_LAST_CALC  7'h7d
`define ADF_SF_FORCE60    7'h7e
`define ADF_SF_FORCE50    7'h7f

// rates and times, each in its own unit
`define ADF_CLK_HZ        32'h017d7840
`define ADF_CLK_NS        32'h28
`define ADF_MOD_HZ        32'h0007d000
`define ADF_RATE60_HZ     32'h3c
`define ADF_RATE50_HZ     32'h32
`define ADF_MIN_RATE_HZ   32'ha
`define ADF_OSR_UNIT      32'h40
`define ADF_AVG_BASE      32'h3
`define ADF_CHOP_EXTRA    32'h3
`define ADF_FIRST_DLY_US  32'h3c
`define ADF_NUM_CONV      32'h2

// derived counts: least time rounds up
`define ADF_FIRST_DLY_CYC ((`ADF_FIRST_DLY_US * 32'h3e8 * `ADF_NUM_CONV \
                          + `ADF_CLK_NS - 32'h1) / `ADF_CLK_NS)
`define ADF_WIN_60        (`ADF_MOD_HZ / `ADF_RATE60_HZ)
`define ADF_WIN_50        (`ADF_MOD_HZ / `ADF_RATE50_HZ)
`define ADF_WIN_MAX       (`ADF_MOD_HZ / `ADF_MIN_RATE_HZ)

// settling in output periods
`define ADF_SETTLE_CHOP   3'h2
`define ADF_SETTLE_PLAIN  3'h3
`define ADF_SETTLE_PLAIN_RA 3'h4
`define ADF_SETTLE_AF     3'h1
`define ADF_SETTLE_AF_RA  3'h2

`endif

// >>> rtl/adf_pkg.sv
// types shared by the decimation filter control block
// assumes field widths that agree with the constants header
package adf_pkg;

    // control register layout, msb first
    typedef struct packed {
        logic       chop;       // system chopping
        logic       ravg;       // running average by two
        logic [5:0] af;         // averaging_factor
        logic       second_notch;     // second_notch
        logic [6:0] sf;         // decimation_factor
    } adf_cfg_t;

    // one result word, both converters
    typedef struct packed {
        logic [15:0] ch1;       // voltage/temperature converter
        logic [15:0] ch0;       // current converter
    } adf_res_t;

    // conversion sequencer
    typedef enum logic [1:0] {
        ADF_ST_BOOT   = 2'b00,
        ADF_ST_SETTLE = 2'b01,
        ADF_ST_RUN    = 2'b10
    } adf_state_t;

endpackage : adf_pkg

// >>> bench/adf_mod_model.sv
// modulator pair model: full-scale current input, zero voltage input
// assumes mod_chop comes registered from clk_sys; bits are async to it
`timescale 1ns/1ns

module adf_mod_model #(
    parameter int SWAP_NS = 5               // settle time of the swap
) (
    input  wire logic       mod_chop,
    output logic [1:0]      mod_bit
);
    logic chop_d = 1'b0;                    // swap as the inputs see it

    // the input swap settles after a short analogue delay
    always @(mod_chop) begin
        chop_d <= #(SWAP_NS) mod_chop;
    end

    // swapped inputs invert both streams, so a chopped window holds the
    // complement of the plain one; constant levels keep counts exact
    assign mod_bit = {chop_d, ~chop_d};
endmodule : adf_mod_model

// >>> bench/adf_filter_ctrl_tb.sv
// self-checking bench for the decimation filter control block
// assumes the modulator model and the block's constants header
`timescale 1ns/1ns
`include "adf_defines.svh"

module adf_filter_ctrl_tb;
    typedef struct packed {
        logic [15:0] cfg;                   // control word
        logic [15:0] win;                   // window in modulator bits
        logic [2:0]  k;                     // windows to first result
    } adf_row_t;

    logic                   clk_sys = 1'b0;
    logic                   rst_n;
    logic [`ADF_ADDR_W-1:0] reg_addr;
    logic [15:0]            reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [15:0]            reg_rdata;
    logic [1:0]             mod_bit;
    logic                   mod_chop;
    logic                   conv_reset;
    logic                   res_valid;
    logic                   res_ready;
    adf_pkg::adf_res_t      res_data;
    int                     err_count = 0;
    int                     check_count = 0;

    // legal factor pairs only, sf 0; plain row last, it feeds overrun
    adf_row_t rows [4] = '{
        '{16'h4000, 16'h0040, 3'h4},
        '{16'h0100, 16'h0100, 3'h1},
        '{16'h8000, 16'h00c3, 3'h2},
        '{16'h0000, 16'h0040, 3'h3}};

    adf_filter_ctrl #(.FIFO_DEPTH(4)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mod_bit(mod_bit), .mod_chop(mod_chop),
        .conv_reset(conv_reset), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data));

    adf_mod_model #(.SWAP_NS(5)) modulators (
        .mod_chop(mod_chop), .mod_bit(mod_bit));

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    // one comparison, counted; mismatch reported at once
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task stop_test();
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // one-cycle register write
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read; data sampled in the following cycle only
    task rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // bounded wait for a result; a hang ends the run
    task wait_res(input int lim, output int n);
        n = 0;
        while (res_valid !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= lim) begin
            err_count++;
            stop_test();
        end
    endtask : wait_res

    // consumer takes one result
    task take();
        @(posedge clk_sys);
        res_ready <= 1'b1;
        @(posedge clk_sys);
        res_ready <= 1'b0;
        #1;
    endtask : take

    initial begin
        logic [15:0] d;
        int          n;
        real         t;
        rst_n = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        res_ready = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values, field readback, unmapped place, control kept after it
        rd(`ADF_CTRL_ADDR, d);
        check(d, `ADF_CTRL_RESET);
        rd(`ADF_STAT_ADDR, d);
        check(d, 16'h0000);
        wr(`ADF_CTRL_ADDR, 16'h00ff);
        rd(`ADF_CTRL_ADDR, d);
        check(d, 16'h00ff);
        wr(12'h51c, 16'hffff);
        rd(12'h51c, d);
        check(d, 16'h0000);
        rd(`ADF_CTRL_ADDR, d);
        check(d, 16'h00ff);
        // rows: restart, first-result time, value and settled status
        for (int i = 0; i < 4; i++) begin
            wr(`ADF_CTRL_ADDR, rows[i].cfg);
            check(conv_reset, 1'b1);
            @(posedge clk_sys);
            #1;
            check(conv_reset, 1'b0);
            wait_res(40000, n);
            // bit tick is 25e6/512e3 = 48.828125 clocks
            t = 3000.0 + rows[i].k * rows[i].win * 48.828125;
            check(n > t - 120.0 && n < t + 120.0, 1'b1);
            check(res_data, {16'h0000, rows[i].win});
            check(mod_chop, 1'b0);
            rd(`ADF_STAT_ADDR, d);
            check(d, 16'h0009);
            if (i < 3) begin
                take();
            end
        end
        // consumer stalls until the fifo overflows
        repeat (6 * 3200) @(posedge clk_sys);
        rd(`ADF_STAT_ADDR, d);
        check(d, 16'h000b);
        n = 0;
        while (res_valid === 1'b1 && n < 8) begin
            take();
            repeat (3) @(posedge clk_sys);
            #1;
            n++;
        end
        check(n >= 4 && n <= 5, 1'b1);
        wr(`ADF_STAT_ADDR, 16'h0002);
        rd(`ADF_STAT_ADDR, d);
        check(d, 16'h0009);
        // a control write returns the sequencer to boot
        wr(`ADF_CTRL_ADDR, 16'h007e);
        rd(`ADF_STAT_ADDR, d);
        check(d, 16'h0000);
        stop_test();
    end
endmodule : adf_filter_ctrl_tb
